// ==== pes_pkg.sv ====
package pes_pkg;

	// function and virtual function counts, power-state code width, severity count
	localparam int NUM_PF = 2;
	localparam int NUM_VF = 6;
	localparam int DS_W = 3;
	localparam int SEV_N = 3;

	// three-bit device power-state codes
	localparam logic [2:0] DS_D0_UNINIT = 3'h0;
	localparam logic [2:0] DS_D0_ACTIVE = 3'h1;
	localparam logic [2:0] DS_D1 = 3'h2;
	localparam logic [2:0] DS_D3HOT = 3'h4;

	// two-bit link power-state codes
	localparam logic [1:0] LP_L0 = 2'h0;
	localparam logic [1:0] LP_L0S = 2'h1;
	localparam logic [1:0] LP_L1 = 2'h2;
	localparam logic [1:0] LP_L2_RSVD = 2'h3;

	// register map, byte addresses
	localparam int ADDR_W = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ERR_EN = 8'h04;
	localparam logic [7:0] REG_DEV_STAT = 8'h08;
	localparam logic [7:0] REG_PWR = 8'h0C;

	// control fields
	localparam int CTRL_ROOT_BIT = 0;
	localparam int CTRL_LTR_BIT = 1;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0003;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// enable and status: three bits per function, cor at +0
	localparam int SEV_COR = 0;
	localparam int SEV_NONFATAL = 1;
	localparam int SEV_FATAL = 2;
	localparam logic [31:0] ERR_EN_RST = 32'h0000_0000;
	localparam logic [31:0] DEV_STAT_RST = 32'h0000_0000;

	// power readback: pf states from bit 0, link state at bit 8
	localparam int PWR_LINK_POS = 8;

	// internal power-management state of one function
	typedef enum logic [1:0] {
		PM_UNINIT,
		PM_ACTIVE,
		PM_D1,
		PM_D3HOT
	} pes_pm_t;

	// internal link power state
	typedef enum logic [2:0] {
		LK_L0,
		LK_L0S,
		LK_L1,
		LK_L2,
		LK_OTHER
	} pes_link_t;

	// one function's error detection strobes
	typedef struct packed {
		logic fatal;
		logic nonfatal;
		logic cor;
	} pes_err_t;

endpackage

// ==== pes_dstate_enc.sv ====
`timescale 1ns/100ps
module pes_dstate_enc
	import pes_pkg::*;
#(
	parameter int N = 2
) (
	input wire pes_pm_t [N-1:0] pm,
	output logic [DS_W*N-1:0] code
);

	function automatic logic [2:0] enc(input pes_pm_t s);
		case (s)
			PM_UNINIT: enc = DS_D0_UNINIT;
			PM_ACTIVE: enc = DS_D0_ACTIVE;
			PM_D1: enc = DS_D1;
			PM_D3HOT: enc = DS_D3HOT;
			default: enc = DS_D0_UNINIT;
		endcase
	endfunction

	always_comb begin
		code = '0;
		for (int i = 0; i < N; i++) begin
			code[DS_W*i +: DS_W] = enc(pm[i]);
		end
	end

endmodule

// ==== pes_err_merge.sv ====
`timescale 1ns/100ps
module pes_err_merge
	import pes_pkg::*;
#(
	parameter int NF = 2
) (
	input wire logic [NF-1:0] detect,
	input wire logic [NF-1:0] enable,
	input wire logic root_port,
	output logic hit
);

	always_comb begin
		if (root_port) begin
			hit = detect[0] & enable[0];
		end else begin
			hit = |(detect & enable);
		end
	end

endmodule

// ==== pes_status_top.sv ====
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module pes_status_top
	import pes_pkg::*;
#(
	parameter int NPF = NUM_PF,
	parameter int NVF = NUM_VF
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire pes_pm_t [NPF-1:0] pf_pm_state,
	input wire pes_pm_t [NVF-1:0] vf_pm_state,
	input wire pes_link_t link_state,
	input wire pes_err_t [NPF-1:0] err_detect,
	output logic [DS_W*NPF-1:0] func_dstate_out,
	output logic [DS_W*NVF-1:0] virt_fn_dstate_out,
	output logic [1:0] link_pstate_out,
	output logic err_cor_out,
	output logic err_nonfatal_out,
	output logic err_fatal_out,
	output logic ltr_enable_out
);

	localparam int EW = SEV_N * NPF;

	logic [31:0] ctrl, next_ctrl;
	logic [31:0] err_en, next_err_en;
	logic [31:0] dev_stat, next_dev_stat;
	logic [31:0] next_rdata;
	logic [DS_W*NPF-1:0] pf_code, next_func_dstate;
	logic [DS_W*NVF-1:0] vf_code, next_virt_dstate;
	logic [1:0] next_link;
	logic next_cor, next_nonfatal, next_fatal, next_ltr;
	logic [SEV_N-1:0] sev_hit;
	logic [EW-1:0] det_flat;
	logic [NPF-1:0] det_sev [SEV_N];
	logic [NPF-1:0] en_sev [SEV_N];
	logic root_port;
	logic wr_ctrl, wr_en, wr_stat;

	assign det_flat = err_detect;
	assign root_port = ctrl[CTRL_ROOT_BIT];
	assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
	assign wr_en = reg_wr && (reg_addr == REG_ERR_EN);
	assign wr_stat = reg_wr && (reg_addr == REG_DEV_STAT);

	function automatic logic [1:0] link_enc(input pes_link_t s);
		case (s)
			LK_L0: link_enc = LP_L0;
			LK_L0S: link_enc = LP_L0S;
			LK_L1: link_enc = LP_L1;
			default: link_enc = LP_L2_RSVD;
		endcase
	endfunction

	pes_dstate_enc #(.N(NPF)) u_pf_enc (
		.pm(pf_pm_state),
		.code(pf_code)
	);

	pes_dstate_enc #(.N(NVF)) u_vf_enc (
		.pm(vf_pm_state),
		.code(vf_code)
	);

	// split detection and enables by severity
	always_comb begin
		for (int s = 0; s < SEV_N; s++) begin
			for (int f = 0; f < NPF; f++) begin
				det_sev[s][f] = det_flat[SEV_N*f + s];
				en_sev[s][f] = err_en[SEV_N*f + s];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < SEV_N; g++) begin : g_sev
			pes_err_merge #(.NF(NPF)) u_merge (
				.detect(det_sev[g]),
				.enable(en_sev[g]),
				.root_port(root_port),
				.hit(sev_hit[g])
			);
		end
	endgenerate

	// register file next values
	always_comb begin
		next_ctrl = ctrl;
		next_err_en = err_en;
		next_dev_stat = dev_stat;
		next_rdata = 32'h0000_0000;
		if (wr_ctrl) begin
			next_ctrl = reg_wdata & CTRL_WMASK;
		end
		if (wr_en) begin
			next_err_en = 32'(reg_wdata[EW-1:0]);
		end
		// status is write-one-to-clear; a new detection wins
		if (wr_stat) begin
			next_dev_stat = dev_stat & ~32'(reg_wdata[EW-1:0]);
		end
		next_dev_stat = next_dev_stat | 32'(det_flat);
		if (reg_rd) begin
			case (reg_addr)
				REG_CTRL: next_rdata = ctrl;
				REG_ERR_EN: next_rdata = err_en;
				REG_DEV_STAT: next_rdata = dev_stat;
				REG_PWR: begin
					next_rdata = 32'(func_dstate_out);
					next_rdata[PWR_LINK_POS +: 2] = link_pstate_out;
				end
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// output next values
	always_comb begin
		next_func_dstate = pf_code;
		next_virt_dstate = vf_code;
		next_link = link_enc(link_state);
		next_cor = sev_hit[SEV_COR];
		next_nonfatal = sev_hit[SEV_NONFATAL];
		next_fatal = sev_hit[SEV_FATAL];
		next_ltr = ctrl[CTRL_LTR_BIT];
	end

	// every output straight from a flop, cleared in reset
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			err_en <= ERR_EN_RST;
			dev_stat <= DEV_STAT_RST;
			reg_rdata <= 32'h0000_0000;
			func_dstate_out <= '0;
			virt_fn_dstate_out <= '0;
			link_pstate_out <= LP_L0;
			err_cor_out <= 1'b0;
			err_nonfatal_out <= 1'b0;
			err_fatal_out <= 1'b0;
			ltr_enable_out <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			err_en <= next_err_en;
			dev_stat <= next_dev_stat;
			reg_rdata <= next_rdata;
			func_dstate_out <= next_func_dstate;
			virt_fn_dstate_out <= next_virt_dstate;
			link_pstate_out <= next_link;
			err_cor_out <= next_cor;
			err_nonfatal_out <= next_nonfatal;
			err_fatal_out <= next_fatal;
			ltr_enable_out <= next_ltr;
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_pf_field_one: assert property (
		pf_pm_state[1] == PM_ACTIVE |=> func_dstate_out[5:3] == 3'h1
	) else $error("function one power field wrong");

	chk_pf_d3_code: assert property (
		pf_pm_state[0] == PM_D3HOT |=> func_dstate_out[2:0] == 3'h4
	) else $error("d3hot code wrong");

	chk_vf_field_one: assert property (
		vf_pm_state[1] == PM_D1 |=> virt_fn_dstate_out[5:3] == 3'h2
	) else $error("vf one power field wrong");

	chk_link_l1_code: assert property (
		link_state == LK_L1 |=> link_pstate_out == 2'h2
	) else $error("link l1 code wrong");

	chk_pf_field_zero: assert property (
		pf_pm_state[0] == PM_ACTIVE |=> func_dstate_out[2:0] == 3'h1
	) else $error("function zero power field wrong");

	chk_pf_uninit_code: assert property (
		pf_pm_state[1] == PM_UNINIT |=> func_dstate_out[5:3] == 3'h0
	) else $error("d0 uninitialized code wrong");

	chk_pf_d1_code: assert property (
		pf_pm_state[0] == PM_D1 |=> func_dstate_out[2:0] == 3'h2
	) else $error("d1 code wrong");

	chk_vf_field_zero: assert property (
		vf_pm_state[0] == PM_ACTIVE |=> virt_fn_dstate_out[2:0] == 3'h1
	) else $error("vf zero power field wrong");

	chk_vf_field_last: assert property (
		vf_pm_state[5] == PM_D3HOT |=> virt_fn_dstate_out[17:15] == 3'h4
	) else $error("last vf power field wrong");

	chk_link_l0_code: assert property (
		link_state == LK_L0 |=> link_pstate_out == 2'h0
	) else $error("link l0 code wrong");

	chk_link_l0s_code: assert property (
		link_state == LK_L0S |=> link_pstate_out == 2'h1
	) else $error("link l0s code wrong");

	chk_link_l2_code: assert property (
		link_state == LK_L2 || link_state == LK_OTHER
			|=> link_pstate_out == 2'h3
	) else $error("link l2 or reserved code wrong");

	chk_ep_cor_pulse: assert property (
		!root_port && err_detect[0].cor && err_en[0] && !err_detect[1].cor
		##1 !err_detect[0].cor && !err_detect[1].cor
		|-> err_cor_out ##1 !err_cor_out
	) else $error("endpoint correctable pulse not one cycle");

	chk_ep_or_func1: assert property (
		!root_port && err_detect[1].cor && err_en[3] |=> err_cor_out
	) else $error("function one correctable not merged");

	chk_rp_cor_local: assert property (
		root_port && err_detect[0].cor && err_en[0] |=> err_cor_out
	) else $error("root port local correctable missed");

	chk_rp_no_remote: assert property (
		root_port && !(err_detect[0].fatal && err_en[2]) |=> !err_fatal_out
	) else $error("root port fatal without local cause");

	chk_ep_nf_pulse: assert property (
		!root_port && err_detect[0].nonfatal && err_en[1] |=> err_nonfatal_out
	) else $error("endpoint non-fatal missed");

	chk_ep_nf_masked: assert property (
		!root_port && !(err_detect[0].nonfatal && err_en[1])
			&& !(err_detect[1].nonfatal && err_en[4]) |=> !err_nonfatal_out
	) else $error("non-fatal pulse without unmasked source");

	chk_ep_fatal_or: assert property (
		!root_port && err_detect[1].fatal && err_en[5] |=> err_fatal_out
	) else $error("function one fatal not merged");

	chk_ltr_follow: assert property (
		wr_ctrl |=> ##1 ltr_enable_out == $past(reg_wdata[CTRL_LTR_BIT], 2)
	) else $error("ltr enable does not follow control");

	chk_ep_cor_masked: assert property (
		!root_port && !(err_detect[0].cor && err_en[0])
			&& !(err_detect[1].cor && err_en[3]) |=> !err_cor_out
	) else $error("correctable pulse without unmasked source");

	chk_ep_nf_or_func1: assert property (
		!root_port && err_detect[1].nonfatal && err_en[4]
			|=> err_nonfatal_out
	) else $error("function one non-fatal not merged");

	chk_ep_fatal_pulse: assert property (
		!root_port && err_detect[0].fatal && err_en[2] |=> err_fatal_out
	) else $error("endpoint fatal missed");

	chk_ep_fatal_masked: assert property (
		!root_port && !(err_detect[0].fatal && err_en[2])
			&& !(err_detect[1].fatal && err_en[5]) |=> !err_fatal_out
	) else $error("fatal pulse without unmasked source");

	chk_rp_nf_local: assert property (
		root_port && err_detect[0].nonfatal && err_en[1]
			|=> err_nonfatal_out
	) else $error("root port local non-fatal missed");

	chk_rp_fatal_local: assert property (
		root_port && err_detect[0].fatal && err_en[2] |=> err_fatal_out
	) else $error("root port local fatal missed");

	chk_rp_cor_remote: assert property (
		root_port && !(err_detect[0].cor && err_en[0]) |=> !err_cor_out
	) else $error("root port correctable without local cause");

	chk_rp_nf_remote: assert property (
		root_port && !(err_detect[0].nonfatal && err_en[1])
			|=> !err_nonfatal_out
	) else $error("root port non-fatal without local cause");

	chk_reset_quiet: assert property (
		disable iff (1'b0) rst |=> !err_cor_out && !err_nonfatal_out
			&& !err_fatal_out && !ltr_enable_out && link_pstate_out == 2'h0
	) else $error("outputs not cleared in reset");

endmodule

// ==== pes_user_model.sv ====
`timescale 1ns/100ps
module pes_user_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic ltr_enable,
	input wire logic root_mode,
	input wire logic ltr_want,
	output logic ltr_send
);
	always_ff @(posedge clk) begin
		ltr_send <= !rst && ltr_want && ltr_enable && !root_mode;
	end
endmodule

// ==== pes_status_top_tb.sv ====
`timescale 1ns/100ps
module pes_status_top_tb
	import pes_pkg::*;
;
	typedef struct {int due; logic [61:0] v;} pes_exp_t;
	logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [5:0] err_detect = 6'h3F;
	pes_pm_t [NUM_PF-1:0] pf_pm_state;
	pes_pm_t [NUM_VF-1:0] vf_pm_state;
	pes_link_t link_state;
	logic [31:0] reg_rdata;
	logic [5:0] func_dstate_out;
	logic [17:0] virt_fn_dstate_out;
	logic [1:0] link_pstate_out;
	logic err_cor_out, err_nonfatal_out, err_fatal_out, ltr_enable_out;
	logic ltr_want = 1'b0;
	logic [15:0] seed = 16'h0002;
	logic [1:0] ctrl_m = 2'h0;
	logic [5:0] en_m = 6'h00, stat_m = 6'h00;
	logic [7:0] pw_m = 8'h00;
	wire [61:0] g = {reg_rdata, err_fatal_out, err_nonfatal_out, err_cor_out,
		ltr_enable_out, link_pstate_out, func_dstate_out, virt_fn_dstate_out};
	pes_exp_t q[$];
	pes_exp_t e;
	int cyc = 0, num_errors = 0, comparisons = 0, i;

	always #12.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	pes_status_top dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .pf_pm_state, .vf_pm_state, .link_state, .err_detect,
		.func_dstate_out, .virt_fn_dstate_out, .link_pstate_out, .err_cor_out,
		.err_nonfatal_out, .err_fatal_out, .ltr_enable_out);
	pes_user_model partner (.clk, .rst, .ltr_enable(ltr_enable_out),
		.root_mode(ctrl_m[0]), .ltr_want, .ltr_send());

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction

	function automatic logic [2:0] enc(input logic [1:0] p);
		return (p == 2'h0) ? 3'h0 : 3'(3'h1 << (p - 2'h1));
	endfunction

	task automatic chk(input string n, input logic [31:0] x,
			input logic [31:0] y);
		comparisons++;
		if (y !== x) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", n, x, y);
		end
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one bus cycle plus fresh random power inputs; notes all expectations
	task automatic cy(input logic w, input logic rd, input logic [7:0] a,
			input logic [31:0] d, input logic [5:0] det);
		logic [31:0] r, rv;
		logic [2:0] ex;
		logic [5:0] pf;
		logic [17:0] vf;
		logic [1:0] lk;
		int k;
		@(posedge clk);
		r = {rnd(), rnd()};
		k = r[18:16] % 5;
		lk = (k > 2) ? 2'h3 : k[1:0];
		for (int j = 0; j < NUM_PF; j++) begin
			pf_pm_state[j] <= pes_pm_t'(r[2*j +: 2]);
			pf[3*j +: 3] = enc(r[2*j +: 2]);
		end
		for (int j = 0; j < NUM_VF; j++) begin
			vf_pm_state[j] <= pes_pm_t'(r[4+2*j +: 2]);
			vf[3*j +: 3] = enc(r[4+2*j +: 2]);
		end
		link_state <= pes_link_t'(k[2:0]);
		reg_wr <= w;
		reg_rd <= rd;
		reg_addr <= a;
		reg_wdata <= d;
		err_detect <= det;
		ltr_want <= r[19];
		case (a)
			REG_CTRL: rv = {30'h0, ctrl_m};
			REG_ERR_EN: rv = {26'h0, en_m};
			REG_DEV_STAT: rv = {26'h0, stat_m};
			REG_PWR: rv = {22'h0, pw_m[7:6], 2'h0, pw_m[5:0]};
			default: rv = 32'h0000_0000;
		endcase
		if (!rd) rv = 32'h0000_0000;
		// root port counts function zero only
		for (int j = 0; j < SEV_N; j++)
			ex[j] = (det[j] & en_m[j]) | (!ctrl_m[0] & det[3+j] & en_m[3+j]);
		q.push_back('{cyc + 2, {rv, ex, ctrl_m[1], lk, pf, vf}});
		pw_m = {lk, pf};
		stat_m = ((w && a == REG_DEV_STAT) ? stat_m & ~d[5:0] : stat_m) | det;
		if (w && a == REG_CTRL) ctrl_m = d[1:0];
		if (w && a == REG_ERR_EN) en_m = d[5:0];
	endtask

	task automatic run(input int n);
		logic [15:0] r;
		for (int t = 0; t < n; t++) begin
			r = rnd();
			case (t % 8)
				0: cy(1'b1, 1'b0, REG_ERR_EN, {26'h0, r[5:0]}, 6'h00);
				3: cy(1'b0, 1'b1, REG_DEV_STAT, 32'h0000_0000, 6'h00);
				5: cy(1'b1, 1'b0, REG_DEV_STAT, {26'h0, r[5:0]}, r[11:6]);
				6: cy(1'b0, 1'b1, REG_PWR, 32'h0000_0000, r[11:6]);
				default: cy(1'b0, 1'b0, REG_PWR, 32'h0000_0000, r[11:6]);
			endcase
		end
		cy(1'b0, 1'b0, REG_PWR, 32'h0000_0000, 6'h00);
	endtask

	task automatic drain(input string n);
		for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge clk);
		if (q.size() > 0) begin
			num_errors++;
			$display("FAIL queue expected 0 seen %0d", q.size());
			test_done();
		end else begin
			$display("test %s done", n);
		end
	endtask

	always @(negedge clk) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			e = q.pop_front();
			chk("reg_rdata", e.v[61:30], g[61:30]);
			chk("err_fatal", e.v[29], g[29]);
			chk("err_nonfatal", e.v[28], g[28]);
			chk("err_cor", e.v[27], g[27]);
			chk("ltr_enable", e.v[26], g[26]);
			chk("link_pstate", e.v[25:24], g[25:24]);
			chk("func_dstate", e.v[23:18], g[23:18]);
			chk("virt_fn_dstate", e.v[17:0], g[17:0]);
		end
	end

	task automatic rst_check();
		@(negedge clk);
		chk("rst_hi", 32'h0000_0000, g[61:30]);
		chk("rst_lo", 32'h0000_0000, g[29:0]);
		@(posedge clk);
		rst <= 1'b0;
		err_detect <= 6'h00;
	endtask

	initial begin
		link_state = LK_L0;
		for (i = 0; i < NUM_PF; i++) pf_pm_state[i] = PM_UNINIT;
		for (i = 0; i < NUM_VF; i++) vf_pm_state[i] = PM_UNINIT;
		repeat (5) @(posedge clk);
		rst_check();
		// unused bits and unmapped place read zero
		cy(1'b1, 1'b0, REG_ERR_EN, 32'hFFFF_FFFF, 6'h00);
		cy(1'b0, 1'b1, REG_ERR_EN, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b1, REG_CTRL, 32'h0000_0000, 6'h00);
		cy(1'b1, 1'b0, REG_CTRL, 32'hFFFF_FFFE, 6'h00);
		cy(1'b1, 1'b0, 8'h10, 32'hFFFF_FFFF, 6'h00);
		cy(1'b0, 1'b1, 8'h10, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b1, REG_CTRL, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b1, REG_PWR, 32'h0000_0000, 6'h3F);
		cy(1'b0, 1'b1, REG_DEV_STAT, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b0, REG_PWR, 32'h0000_0000, 6'h00);
		drain("registers");
		run(96);
		drain("endpoint");
		cy(1'b1, 1'b0, REG_CTRL, 32'h0000_0001, 6'h00);
		run(96);
		drain("root");
		// reset in mid run with detects held high
		rst <= 1'b1;
		err_detect <= 6'h3F;
		repeat (2) @(posedge clk);
		rst_check();
		ctrl_m = 2'h0;
		en_m = 6'h00;
		stat_m = 6'h00;
		cy(1'b0, 1'b1, REG_CTRL, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b1, REG_DEV_STAT, 32'h0000_0000, 6'h00);
		cy(1'b0, 1'b0, REG_PWR, 32'h0000_0000, 6'h00);
		drain("reset");
		test_done();
	end
endmodule
